// ### rtl/emi_consts.vh
`ifndef EMI_CONSTS_VH
`define EMI_CONSTS_VH

// ----------------------------------------------------------------
// Register addresses and reset values
// ----------------------------------------------------------------
`define EMI_ADDR_TIMING     8'h84
`define EMI_ADDR_CONFIG     8'h85
`define EMI_ADDR_PAGE       8'hAA
`define EMI_RST_TIMING      8'hFF
`define EMI_RST_CONFIG      8'h03
`define EMI_RST_PAGE        8'h00
`define EMI_CFG_WMASK       8'h5F

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define EMI_CFG_FIFO        6
`define EMI_CFG_MUXSEL      4
`define EMI_CFG_MODE        3:2
`define EMI_CFG_ALE         1:0
`define EMI_TC_SETUP        7:6
`define EMI_TC_STROBE       5:2
`define EMI_TC_HOLD         1:0

// ----------------------------------------------------------------
// Memory map modes and windows
// ----------------------------------------------------------------
`define EMI_MODE_INTERNAL   2'h0
`define EMI_MODE_SPLIT      2'h1
`define EMI_MODE_BANK       2'h2
`define EMI_MODE_EXTERNAL   2'h3
`define EMI_FIFO_LO         16'h0400
`define EMI_FIFO_HI         16'h07FF
`define EMI_SPLIT_BOUNDARY  16'h2000

`endif

// ### rtl/emi_xram.v
// ----------------------------------------------------------------
// On-chip data RAM, registered read
// ----------------------------------------------------------------
module emi_xram #(
    parameter AW = 12
) (
    input  wire          clock,
    input  wire          ce,
    input  wire          en,
    input  wire          we,
    input  wire [AW-1:0] addr,
    input  wire [7:0]    wdata,
    output reg  [7:0]    rdata
);
    reg [7:0] mem [0:(1<<AW)-1];

    always @(posedge clock) begin
        if (ce && en) begin
            if (we) begin
                mem[addr] <= wdata;
            end
            rdata <= mem[addr];
        end
    end
endmodule

// ### rtl/emi_memory_port.v
`include "emi_consts.vh"

module emi_memory_port #(
    parameter        XRAM_AW        = 12,
    parameter [15:0] SPLIT_BOUNDARY = `EMI_SPLIT_BOUNDARY
) (
    input  wire        clock,
    input  wire        resetn,
    input  wire        ce,
    input  wire [7:0]  sfr_addr,
    input  wire [7:0]  sfr_wdata,
    input  wire        sfr_write,
    output reg  [7:0]  sfr_rdata,
    input  wire        movx_req,
    input  wire        movx_write,
    input  wire        movx_wide,
    input  wire [15:0] movx_dptr,
    input  wire [7:0]  movx_reg_low,
    input  wire [7:0]  movx_wdata,
    output reg         movx_done,
    output reg  [7:0]  movx_rdata,
    output reg         movx_busy,
    output reg         usb_req,
    output reg         usb_write,
    output reg  [9:0]  usb_addr,
    output reg  [7:0]  usb_wdata,
    input  wire        usb_ack,
    input  wire [7:0]  usb_rdata,
    output reg  [7:0]  addr_hi_out,
    output reg         addr_hi_oe_n,
    output reg  [7:0]  addr_lo_out,
    output reg         addr_lo_oe_n,
    output reg  [7:0]  ad_out,
    output reg         ad_oe_n,
    input  wire [7:0]  ad_in,
    output reg         ale,
    output reg         rd_n,
    output reg         wr_n,
    output reg         port_claim
);
    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    localparam [3:0] ST_IDLE    = 4'h0;
    localparam [3:0] ST_LAUNCH  = 4'h1;
    localparam [3:0] ST_ALEH    = 4'h2;
    localparam [3:0] ST_ALEL    = 4'h3;
    localparam [3:0] ST_SETUP   = 4'h4;
    localparam [3:0] ST_STROBE  = 4'h5;
    localparam [3:0] ST_HOLD    = 4'h6;
    localparam [3:0] ST_TURN    = 4'h7;
    localparam [3:0] ST_RELEASE = 4'h8;
    localparam [3:0] ST_INTRAM  = 4'h9;
    localparam [3:0] ST_USBW    = 4'hA;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg  [7:0]  cfg;
    reg  [7:0]  timing;
    reg  [7:0]  page;

    reg  [3:0]  state;
    reg  [3:0]  cnt;
    reg  [15:0] acc_addr;
    reg         acc_write;
    reg  [7:0]  acc_wdata;
    reg         acc_drive_hi;
    reg         acc_mux;
    reg  [7:0]  acc_timing;
    reg  [1:0]  acc_ale;
    reg  [7:0]  acc_rdata;

    reg  [3:0]  next_state;
    reg  [3:0]  next_cnt;
    reg  [15:0] next_acc_addr;
    reg         next_acc_write;
    reg  [7:0]  next_acc_wdata;
    reg         next_acc_drive_hi;
    reg         next_acc_mux;
    reg  [7:0]  next_acc_timing;
    reg  [1:0]  next_acc_ale;
    reg         take_int;
    reg         take_usb;
    reg  [15:0] eff_addr;
    reg         on_chip;
    reg         in_window;
    reg         claimed;

    wire [7:0]  mem_rdata;

    // Enter setup phase, or skip straight to strobe when setup is zero
    function [3:0] setup_state;
        input [1:0] setup_code;
        begin
            setup_state = (setup_code != 2'h0) ? ST_SETUP : ST_STROBE;
        end
    endfunction

    function [3:0] setup_count;
        input [7:0] tc;
        begin
            if (tc[`EMI_TC_SETUP] != 2'h0)
                setup_count = {2'h0, tc[`EMI_TC_SETUP] - 2'h1};
            else
                setup_count = tc[`EMI_TC_STROBE];
        end
    endfunction

    emi_xram #(
        .AW (XRAM_AW)
    ) u_xram (
        .clock (clock),
        .ce    (ce),
        .en    (take_int),
        .we    (movx_write),
        .addr  (eff_addr[XRAM_AW-1:0]),
        .wdata (movx_wdata),
        .rdata (mem_rdata)
    );

    // ------------------------------------------------------------
    // Address decode and sequencing
    // ------------------------------------------------------------
    always @* begin
        next_state        = state;
        next_cnt          = cnt;
        next_acc_addr     = acc_addr;
        next_acc_write    = acc_write;
        next_acc_wdata    = acc_wdata;
        next_acc_drive_hi = acc_drive_hi;
        next_acc_mux      = acc_mux;
        next_acc_timing   = acc_timing;
        next_acc_ale      = acc_ale;
        take_int          = 1'b0;
        take_usb          = 1'b0;
        eff_addr  = movx_wide ? movx_dptr : {page, movx_reg_low};
        in_window = cfg[`EMI_CFG_FIFO] && (eff_addr >= `EMI_FIFO_LO)
                    && (eff_addr <= `EMI_FIFO_HI);
        case (cfg[`EMI_CFG_MODE])
            `EMI_MODE_INTERNAL: on_chip = 1'b1;
            `EMI_MODE_SPLIT:    on_chip = eff_addr < SPLIT_BOUNDARY;
            `EMI_MODE_BANK:     on_chip = eff_addr < SPLIT_BOUNDARY;
            default:            on_chip = 1'b0;
        endcase
        case (state)
            ST_IDLE: begin
                if (movx_req) begin
                    if (in_window) begin
                        take_usb   = 1'b1;
                        next_state = ST_USBW;
                    end else if (on_chip) begin
                        take_int   = 1'b1;
                        next_state = ST_INTRAM;
                    end else begin
                        next_state        = ST_LAUNCH;
                        next_acc_addr     = eff_addr;
                        next_acc_write    = movx_write;
                        next_acc_wdata    = movx_wdata;
                        next_acc_drive_hi = movx_wide ||
                            (cfg[`EMI_CFG_MODE] == `EMI_MODE_BANK);
                        next_acc_mux      = ~cfg[`EMI_CFG_MUXSEL];
                        next_acc_timing   = timing;
                        next_acc_ale      = cfg[`EMI_CFG_ALE];
                    end
                end
            end
            ST_LAUNCH: begin
                if (acc_mux) begin
                    next_state = ST_ALEH;
                    next_cnt   = {2'h0, acc_ale};
                end else begin
                    next_state = setup_state(acc_timing[`EMI_TC_SETUP]);
                    next_cnt   = setup_count(acc_timing);
                end
            end
            ST_ALEH: begin
                if (cnt == 4'h0) begin
                    next_state = ST_ALEL;
                    next_cnt   = {2'h0, acc_ale};
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            ST_ALEL: begin
                if (cnt == 4'h0) begin
                    next_state = setup_state(acc_timing[`EMI_TC_SETUP]);
                    next_cnt   = setup_count(acc_timing);
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            ST_SETUP: begin
                if (cnt == 4'h0) begin
                    next_state = ST_STROBE;
                    next_cnt   = acc_timing[`EMI_TC_STROBE];
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            ST_STROBE: begin
                if (cnt == 4'h0) begin
                    if (acc_timing[`EMI_TC_HOLD] != 2'h0) begin
                        next_state = ST_HOLD;
                        next_cnt   = {2'h0, acc_timing[`EMI_TC_HOLD] - 2'h1};
                    end else begin
                        next_state = ST_TURN;
                    end
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            ST_HOLD: begin
                if (cnt == 4'h0)
                    next_state = ST_TURN;
                else
                    next_cnt = cnt - 4'h1;
            end
            ST_TURN:    next_state = ST_RELEASE;
            ST_RELEASE: next_state = ST_IDLE;
            ST_INTRAM:  next_state = ST_IDLE;
            ST_USBW: begin
                if (usb_ack)
                    next_state = ST_IDLE;
            end
            default:    next_state = ST_IDLE;
        endcase
        claimed = (next_state >= ST_LAUNCH) && (next_state <= ST_TURN);
    end

    // ------------------------------------------------------------
    // Registers, sequencer state and pins
    // ------------------------------------------------------------
    always @(posedge clock) begin
        if (!resetn) begin
            cfg          <= `EMI_RST_CONFIG;
            timing       <= `EMI_RST_TIMING;
            page         <= `EMI_RST_PAGE;
            sfr_rdata    <= 8'h00;
            state        <= ST_IDLE;
            cnt          <= 4'h0;
            acc_addr     <= 16'h0000;
            acc_write    <= 1'b0;
            acc_wdata    <= 8'h00;
            acc_drive_hi <= 1'b0;
            acc_mux      <= 1'b0;
            acc_timing   <= `EMI_RST_TIMING;
            acc_ale      <= 2'h0;
            acc_rdata    <= 8'h00;
            movx_done    <= 1'b0;
            movx_rdata   <= 8'h00;
            movx_busy    <= 1'b0;
            usb_req      <= 1'b0;
            usb_write    <= 1'b0;
            usb_addr     <= 10'h000;
            usb_wdata    <= 8'h00;
            addr_hi_out  <= 8'h00;
            addr_hi_oe_n <= 1'b1;
            addr_lo_out  <= 8'h00;
            addr_lo_oe_n <= 1'b1;
            ad_out       <= 8'h00;
            ad_oe_n      <= 1'b1;
            ale          <= 1'b0;
            rd_n         <= 1'b1;
            wr_n         <= 1'b1;
            port_claim   <= 1'b0;
        end else if (ce) begin
            if (sfr_write) begin
                case (sfr_addr)
                    `EMI_ADDR_CONFIG: cfg    <= sfr_wdata & `EMI_CFG_WMASK;
                    `EMI_ADDR_TIMING: timing <= sfr_wdata;
                    `EMI_ADDR_PAGE:   page   <= sfr_wdata;
                    default: ;
                endcase
            end
            case (sfr_addr)
                `EMI_ADDR_CONFIG: sfr_rdata <= cfg & `EMI_CFG_WMASK;
                `EMI_ADDR_TIMING: sfr_rdata <= timing;
                `EMI_ADDR_PAGE:   sfr_rdata <= page;
                default:          sfr_rdata <= 8'h00;
            endcase

            state        <= next_state;
            cnt          <= next_cnt;
            acc_addr     <= next_acc_addr;
            acc_write    <= next_acc_write;
            acc_wdata    <= next_acc_wdata;
            acc_drive_hi <= next_acc_drive_hi;
            acc_mux      <= next_acc_mux;
            acc_timing   <= next_acc_timing;
            acc_ale      <= next_acc_ale;

            // Sample read data on last strobe cycle
            if (state == ST_STROBE && cnt == 4'h0 && !acc_write)
                acc_rdata <= ad_in;

            movx_busy <= (next_state != ST_IDLE);
            movx_done <= (state == ST_RELEASE) || (state == ST_INTRAM) ||
                         (state == ST_USBW && usb_ack);
            if (state == ST_RELEASE && !acc_write)
                movx_rdata <= acc_rdata;
            else if (state == ST_INTRAM)
                movx_rdata <= mem_rdata;
            else if (state == ST_USBW && usb_ack)
                movx_rdata <= usb_rdata;

            usb_req <= take_usb;
            if (take_usb) begin
                usb_write <= movx_write;
                usb_addr  <= eff_addr[9:0];
                usb_wdata <= movx_wdata;
            end

            // Pins follow the state being entered
            port_claim   <= claimed;
            addr_hi_out  <= next_acc_addr[15:8];
            addr_hi_oe_n <= ~(claimed && next_acc_drive_hi);
            addr_lo_out  <= next_acc_addr[7:0];
            addr_lo_oe_n <= ~(claimed && !next_acc_mux);
            ale          <= next_acc_mux && (next_state == ST_ALEH);
            rd_n <= ~(next_state == ST_STROBE && !next_acc_write);
            wr_n <= ~(next_state == ST_STROBE && next_acc_write);
            if (next_acc_mux && (next_state == ST_LAUNCH || next_state == ST_ALEH ||
                                 next_state == ST_ALEL)) begin
                ad_out  <= next_acc_addr[7:0];
                ad_oe_n <= 1'b0;
            end else begin
                ad_out  <= next_acc_wdata;
                ad_oe_n <= ~(claimed && next_acc_write);
            end
        end
    end
endmodule

// ### bench/emi_ext_sram.sv
module emi_ext_sram (
    input  logic [7:0] addr_lo_out,
    input  logic       addr_lo_oe_n,
    input  logic [7:0] ad_out,
    input  logic       ale,
    input  logic       rd_n,
    input  logic       wr_n,
    output logic [7:0] ad_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [256];
    logic [7:0] lat;
    logic [7:0] idx;
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
    end
    // External latch: transparent while strobe high
    always_latch if (ale) lat <= ad_out;
    assign idx = addr_lo_oe_n ? lat : addr_lo_out;
    always @(posedge wr_n) mem[idx] <= ad_out;
    // Released bus shows the inverse, never the held value
    assign ad_in = rd_n ? ~mem[idx] : mem[idx];
endmodule

// ### bench/emi_memory_port_sva.sv
module emi_memory_port_sva (
    input logic clock,
    input logic resetn,
    input logic ce,
    input logic movx_req,
    input logic movx_busy,
    input logic movx_done,
    input logic usb_req,
    input logic port_claim,
    input logic rd_n,
    input logic wr_n,
    input logic ale,
    input logic ad_oe_n,
    input logic addr_hi_oe_n,
    input logic addr_lo_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    chk_idle_pins: assert property (!port_claim |->
        rd_n && wr_n && !ale && ad_oe_n && addr_hi_oe_n && addr_lo_oe_n)
        else $error("pins active outside access");
    chk_read_release: assert property (!rd_n |-> ad_oe_n)
        else $error("data driven during read");
    chk_ale_addr: assert property (ale |-> !ad_oe_n && addr_lo_oe_n)
        else $error("latch strobe without address on shared pins");
    chk_usb_quiet: assert property (usb_req |-> !port_claim && rd_n && wr_n)
        else $error("window access touched pins");
    chk_min_claim: assert property ($rose(port_claim) |-> port_claim[*3])
        else $error("off-chip access too short");
    chk_done_after: assert property ($fell(port_claim) |=> movx_done)
        else $error("no completion after pins released");
    chk_take_busy: assert property (ce && movx_req && !movx_busy |=> movx_busy)
        else $error("request not taken");
    chk_take_done: assert property (ce && movx_req && !movx_busy |-> ##[2:60] movx_done)
        else $error("access never completed");
    chk_done_idle: assert property (movx_done |-> !movx_busy && !port_claim)
        else $error("completion while still busy");
    chk_strobe_claim: assert property (!(rd_n && wr_n) |-> $past(port_claim))
        else $error("strobe without address setup");
endmodule

// ### bench/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock, resetn, ce, sfr_write, movx_req, movx_write, movx_wide, usb_ack;
    logic        movx_done, movx_busy, usb_req, usb_write, ad_oe_n, ale, rd_n, wr_n;
    logic        port_claim, addr_hi_oe_n, addr_lo_oe_n;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, movx_reg_low, movx_wdata, movx_rdata;
    logic [7:0]  usb_wdata, usb_rdata, addr_hi_out, addr_lo_out, ad_out, ad_in, rd_v;
    logic [7:0]  rdv, hi_v, lo_v, tc, cf;
    logic [9:0]  usb_addr, uaddr;
    logic [8:0]  uwd;
    logic [15:0] movx_dptr;
    int          miscompares = 0, n_compared = 0, n, strb, alec;
    logic        claim, hi_seen, usb_seen;

    emi_memory_port emi_memory_port_inst (
        .clock        (clock),
        .resetn       (resetn),
        .ce           (ce),
        .sfr_addr     (sfr_addr),
        .sfr_wdata    (sfr_wdata),
        .sfr_write    (sfr_write),
        .sfr_rdata    (sfr_rdata),
        .movx_req     (movx_req),
        .movx_write   (movx_write),
        .movx_wide    (movx_wide),
        .movx_dptr    (movx_dptr),
        .movx_reg_low (movx_reg_low),
        .movx_wdata   (movx_wdata),
        .movx_done    (movx_done),
        .movx_rdata   (movx_rdata),
        .movx_busy    (movx_busy),
        .usb_req      (usb_req),
        .usb_write    (usb_write),
        .usb_addr     (usb_addr),
        .usb_wdata    (usb_wdata),
        .usb_ack      (usb_ack),
        .usb_rdata    (usb_rdata),
        .addr_hi_out  (addr_hi_out),
        .addr_hi_oe_n (addr_hi_oe_n),
        .addr_lo_out  (addr_lo_out),
        .addr_lo_oe_n (addr_lo_oe_n),
        .ad_out       (ad_out),
        .ad_oe_n      (ad_oe_n),
        .ad_in        (ad_in),
        .ale          (ale),
        .rd_n         (rd_n),
        .wr_n         (wr_n),
        .port_claim   (port_claim)
    );
    emi_ext_sram emi_ext_sram_inst (
        .addr_lo_out  (addr_lo_out),
        .addr_lo_oe_n (addr_lo_oe_n),
        .ad_out       (ad_out),
        .ale          (ale),
        .rd_n         (rd_n),
        .wr_n         (wr_n),
        .ad_in        (ad_in)
    );

    always #25 clock = ~clock;

    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task end_sim();
        $display("compared=%0d mismatched=%0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task sfr_wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_write = 1'b1;
        @(negedge clock);
        sfr_write = 1'b0;
        @(negedge clock);
    endtask
    task sfr_rd(input logic [7:0] a);
        sfr_addr = a;
        @(negedge clock);
        rd_v = sfr_rdata;
    endtask
    // ----------------------------------------------------------------
    // One access, pins watched each cycle
    // ----------------------------------------------------------------
    task acc(input logic w, input logic wd, input logic [15:0] dp,
             input logic [7:0] lo, input logic [7:0] d);
        movx_req = 1'b1;
        movx_write = w;
        movx_wide = wd;
        movx_dptr = dp;
        movx_reg_low = lo;
        movx_wdata = d;
        {claim, hi_seen, usb_seen, strb, alec, hi_v, lo_v} = '0;
        @(negedge clock);
        n = 1;
        movx_req = 1'b0;
        while (movx_done !== 1'b1 && n < 200) begin
            if (port_claim === 1'b1) claim = 1'b1;
            if (addr_hi_oe_n === 1'b0) begin
                hi_seen = 1'b1;
                hi_v = addr_hi_out;
            end
            if (addr_lo_oe_n === 1'b0) lo_v = addr_lo_out;
            if (ale === 1'b1) begin
                alec++;
                lo_v = ad_out;
            end
            if ((rd_n & wr_n) === 1'b0) strb++;
            if (usb_req === 1'b1) begin
                usb_seen = 1'b1;
                uaddr = usb_addr;
                uwd = {usb_write, usb_wdata};
            end
            usb_ack = (usb_req === 1'b1);
            @(negedge clock);
            n++;
        end
        usb_ack = 1'b0;
        rdv = movx_rdata;
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_regs();
        sfr_rd(8'h85);
        chk(rd_v, 8'h03);
        sfr_rd(8'h84);
        chk(rd_v, 8'hFF);
        sfr_rd(8'hAA);
        chk(rd_v, 8'h00);
        sfr_rd(8'h00);
        chk(rd_v, 8'h00);
        sfr_wr(8'h85, 8'hFF);
        sfr_rd(8'h85);
        chk(rd_v, 8'h5F);
        sfr_wr(8'hAA, 8'h5A);
        sfr_rd(8'hAA);
        chk(rd_v, 8'h5A);
        // Write with clock enable low must not land
        ce = 1'b0;
        sfr_wr(8'hAA, 8'h77);
        ce = 1'b1;
        sfr_rd(8'hAA);
        chk(rd_v, 8'h5A);
        $display("t_regs done");
    endtask
    task t_internal();
        sfr_wr(8'h85, 8'h00);
        sfr_wr(8'hAA, 8'h12);
        acc(1, 0, 16'h0000, 8'h34, 8'hA5);
        chk(n, 2);
        chk(claim, 0);
        acc(0, 1, 16'h1234, 8'h00, 8'h00);
        chk(rdv, 8'hA5);
        acc(0, 1, 16'h3234, 8'h00, 8'h00);
        chk(rdv, 8'hA5);
        acc(1, 1, 16'h3234, 8'h00, 8'h6B);
        acc(0, 0, 16'h0000, 8'h34, 8'h00);
        chk(rdv, 8'h6B);
        $display("t_internal done");
    endtask
    task t_fifo();
        usb_rdata = 8'h3C;
        sfr_wr(8'h85, 8'h40);
        acc(1, 1, 16'h0500, 8'h00, 8'h77);
        chk(usb_seen, 1);
        chk(uaddr, 10'h100);
        chk(uwd, 9'h177);
        chk(claim, 0);
        sfr_wr(8'hAA, 8'h04);
        acc(0, 0, 16'h0000, 8'hFF, 8'h00);
        chk(uaddr, 10'h0FF);
        chk(uwd, 9'h000);
        chk(rdv, 8'h3C);
        sfr_wr(8'h85, 8'h00);
        acc(0, 1, 16'h0500, 8'h00, 8'h00);
        chk(usb_seen, 0);
        $display("t_fifo done");
    endtask
    task t_nonmux();
        logic [31:0] tcs;
        tcs = 32'hFF9A4500;
        sfr_wr(8'h85, 8'h14);
        for (int i = 0; i < 4; i++) begin
            tc = tcs[8*i +: 8];
            sfr_wr(8'h84, tc);
            acc(1, 1, {8'h80, 8'h10 + i[7:0]}, 8'h00, 8'hA0 + i[7:0]);
            chk(n, tc[7:6] + tc[5:2] + 1 + tc[1:0] + 4);
            chk(strb, tc[5:2] + 1);
            chk(hi_v, 8'h80);
            chk(lo_v, 8'h10 + i[7:0]);
            acc(0, 1, {8'h80, 8'h10 + i[7:0]}, 8'h00, 8'h00);
            chk(rdv, 8'hA0 + i[7:0]);
        end
        $display("t_nonmux done");
    endtask
    task t_modes();
        logic [31:0] cfs;
        logic [31:0] pgs;
        logic [7:0]  exs;
        logic [1:0]  ex;
        cfs = 32'h141C1814;
        pgs = 32'h00008080;
        exs = 8'h2E;
        sfr_wr(8'h84, 8'h00);
        for (int i = 0; i < 4; i++) begin
            ex = exs[2*i +: 2];
            sfr_wr(8'h85, cfs[8*i +: 8]);
            sfr_wr(8'hAA, pgs[8*i +: 8]);
            acc(1, 0, 16'h0000, 8'h60 + i[7:0], 8'hC0 + i[7:0]);
            chk(claim, ex[1]);
            chk(hi_seen, ex[0]);
            if (ex[1]) begin
                chk(lo_v, 8'h60 + i[7:0]);
                if (ex[0])
                    chk(hi_v, 8'h80);
                acc(0, 1, {8'h80, 8'h60 + i[7:0]}, 8'h00, 8'h00);
                chk(rdv, 8'hC0 + i[7:0]);
            end
        end
        $display("t_modes done");
    endtask
    task t_mux();
        sfr_wr(8'h84, 8'h00);
        for (int c = 0; c < 4; c++) begin
            cf = 8'h04 | c[7:0];
            sfr_wr(8'h85, cf);
            acc(1, 1, {8'h90, 8'h20 + c[7:0]}, 8'h00, 8'h50 + c[7:0]);
            chk(n, 5 + 2 * (c + 1));
            chk(alec, c + 1);
            chk(lo_v, 8'h20 + c[7:0]);
            chk(hi_v, 8'h90);
            acc(0, 1, {8'h90, 8'h20 + c[7:0]}, 8'h00, 8'h00);
            chk(rdv, 8'h50 + c[7:0]);
        end
        $display("t_mux done");
    endtask

    initial begin
        {clock, resetn, sfr_write, movx_req, movx_write, movx_wide, usb_ack} = '0;
        ce = 1'b1;
        {sfr_addr, sfr_wdata, movx_reg_low, movx_wdata, usb_rdata, movx_dptr} = '0;
        repeat (16) @(negedge clock);
        resetn = 1'b1;
        @(negedge clock);
        t_regs();
        t_internal();
        t_fifo();
        t_nonmux();
        t_modes();
        t_mux();
        end_sim();
    end
    initial begin
        #1000000;
        miscompares++;
        end_sim();
    end
endmodule

bind emi_memory_port emi_memory_port_sva emi_memory_port_sva_inst (
    .clock        (clock),
    .resetn       (resetn),
    .ce           (ce),
    .movx_req     (movx_req),
    .movx_busy    (movx_busy),
    .movx_done    (movx_done),
    .usb_req      (usb_req),
    .port_claim   (port_claim),
    .rd_n         (rd_n),
    .wr_n         (wr_n),
    .ale          (ale),
    .ad_oe_n      (ad_oe_n),
    .addr_hi_oe_n (addr_hi_oe_n),
    .addr_lo_oe_n (addr_lo_oe_n)
);
